// *** rtl/txbcp_parser.sv ***
// transmit buffer command parser: strips commands, offsets and filler, forwards bytes
//
// Behaviour
// - command A bit 13 first, bit 12 last
// - command A size bits bound the buffer
// - offset, size plus alignment give filler dword count
// - packet byte total mismatch sets error flag
// - command B tag copied for packet status
// - checksum needs B bit14, first, engine enable
// - B bit 13 suppresses appended CRC
// - B bit 12 suppresses short frame padding
// - padding disabled still forces CRC append
// - payload follows the command words
// - offset low bits select first byte lane
// - offset upper bits skip up to seven dwords
// - unused trailing bytes never forwarded
// - end alignment of 4, 16, 32 bytes
// - filler dwords are discarded
// - alignment codes 00, 01, 10; 11 reserved
// - A bit 31 raises buffer loaded flag
// - command B only follows first buffers
`include "txbcp_map.svh"
module txbcp_parser
  import txbcp_pkg::*;
#(
  parameter int FIFO_DEPTH = `TXBCP_FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // host dword stream
  input  wire logic [31:0] IN_DATA,
  input  wire logic        IN_VALID,
  output logic             IN_READY,
  // byte stream towards the mac side fifo
  output logic [7:0]       OUT_DATA,
  output logic             OUT_LAST,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  // packet controls from command B
  output logic [15:0]      FRAME_TAG,
  output logic             CHECKSUM_REQUEST,
  output logic             CRC_APPEND,
  output logic             PAD_ENABLE,
  // configuration and status
  input  wire logic        CHECKSUM_ENGINE_ENABLE,
  input  wire logic        ERROR_CLEAR,
  output logic             TRANSMIT_ERROR_FLAG,
  output logic             BUFFER_LOADED_FLAG
);
  txbcp_state_type st, next_st;
  logic [10:0]     cnt, next_cnt;
  logic [11:0]     total, next_total;
  logic [10:0]     pkt_len, next_pkt_len;
  logic [2:0]      skip, next_skip;
  logic [2:0]      pad, next_pad;
  logic [1:0]      off_byte, next_off_byte;
  logic [1:0]      idx, next_idx;
  logic [31:0]     hold, next_hold;
  logic            first, next_first;
  logic            last, next_last;
  logic            done_req, next_done_req;
  logic            first_word, next_first_word;
  logic [15:0]     next_tag;
  logic            next_ck, next_crc, next_padq, next_err, next_loaded;
  logic            err_set, go_body, go_tail, buf_end, push, fifo_ready;
  logic [8:0]      fifo_out;
  // dwords the buffer body occupies before filler, low bits suffice for padding
  function automatic logic [2:0] body_dwords(input logic [2:0] skp, input logic [1:0] ob, input logic [10:0] sz);
    logic [12:0] sum;
    sum = 13'(ob) + 13'(sz) + 13'h3;
    return (sz == 11'h0) ? skp : skp + sum[4:2];
  endfunction
  function automatic logic [2:0] filler_dwords(input logic [2:0] n, input logic [1:0] al);
    logic [2:0] mask;
    mask = (al == `TXBCP_ALIGN_16) ? `TXBCP_MASK_16 : (al == `TXBCP_ALIGN_32) ? `TXBCP_MASK_32 : 3'h0;
    return (3'h0 - n) & mask;
  endfunction
  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] lane);
    return w[{lane, 3'h0} +: 8];
  endfunction

  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_total = total;
    next_pkt_len = pkt_len;
    next_skip = skip;
    next_pad = pad;
    next_off_byte = off_byte;
    next_idx = idx;
    next_hold = hold;
    next_first = first;
    next_last = last;
    next_done_req = done_req;
    next_first_word = first_word;
    next_tag = FRAME_TAG;
    next_ck = CHECKSUM_REQUEST;
    next_crc = CRC_APPEND;
    next_padq = PAD_ENABLE;
    err_set = 1'b0;
    go_body = 1'b0;
    go_tail = 1'b0;
    buf_end = 1'b0;
    push = 1'b0;
    IN_READY = 1'b0;
    case (st)
      ST_CMDA:
      begin
        IN_READY = 1'b1;
        if (IN_VALID)
        begin
          next_first = IN_DATA[`TXBCP_A_FIRST_BIT];
          next_last = IN_DATA[`TXBCP_A_LAST_BIT];
          next_done_req = IN_DATA[`TXBCP_A_DONE_BIT];
          next_cnt = IN_DATA[`TXBCP_SIZE_HI:0];
          next_off_byte = IN_DATA[`TXBCP_A_OFF_LO +: 2];
          next_skip = IN_DATA[`TXBCP_A_OFF_LO + 2 +: 3];
          next_first_word = 1'b1;
          // restart the running total on a first buffer
          next_total = next_first ? 12'(next_cnt) : total + 12'(next_cnt);
          next_pad = filler_dwords(body_dwords(next_skip, next_off_byte, next_cnt),
                                   IN_DATA[`TXBCP_A_ALIGN_LO +: 2]);
          // reserved alignment code is treated as four bytes and reported
          if (IN_DATA[`TXBCP_A_ALIGN_LO +: 2] == `TXBCP_ALIGN_RSVD)
            err_set = 1'b1;
          if (next_first)
            next_st = ST_CMDB;
          else
            go_body = 1'b1;
        end
      end
      ST_CMDB:
      begin
        IN_READY = 1'b1;
        if (IN_VALID)
        begin
          next_tag = IN_DATA[`TXBCP_B_TAG_LO +: 16];
          next_ck = IN_DATA[`TXBCP_B_CK_BIT] && first && CHECKSUM_ENGINE_ENABLE;
          next_crc = !IN_DATA[`TXBCP_B_NOCRC_BIT] || IN_DATA[`TXBCP_B_NOPAD_BIT];
          next_padq = !IN_DATA[`TXBCP_B_NOPAD_BIT];
          next_pkt_len = IN_DATA[`TXBCP_SIZE_HI:0];
          go_body = 1'b1;
        end
      end
      ST_SKIP:
      begin
        IN_READY = 1'b1;
        if (IN_VALID)
        begin
          next_skip = skip - 3'h1;
          if (skip == 3'h1)
            go_body = 1'b1;
        end
      end
      ST_DATA:
      begin
        IN_READY = 1'b1;
        if (IN_VALID)
        begin
          next_hold = IN_DATA;
          next_idx = first_word ? off_byte : 2'h0;
          next_first_word = 1'b0;
          next_st = ST_BYTES;
        end
      end
      ST_BYTES:
      begin
        if (fifo_ready)
        begin
          push = 1'b1;
          next_cnt = cnt - 11'h1;
          next_idx = idx + 2'h1;
          // remaining lanes of the final dword are dropped here
          if (cnt == 11'h1)
            go_tail = 1'b1;
          else if (idx == 2'h3)
            next_st = ST_DATA;
        end
      end
      ST_PAD:
      begin
        IN_READY = 1'b1;
        if (IN_VALID)
        begin
          next_pad = pad - 3'h1;
          if (pad == 3'h1)
            go_tail = 1'b1;
        end
      end
      default:
        next_st = ST_CMDA;
    endcase
    if (go_body)
    begin
      if (next_skip != 3'h0)
        next_st = ST_SKIP;
      else if (next_cnt != 11'h0)
        next_st = ST_DATA;
      else
        go_tail = 1'b1;
    end
    if (go_tail)
    begin
      if (next_pad != 3'h0)
        next_st = ST_PAD;
      else
      begin
        buf_end = 1'b1;
        next_st = ST_CMDA;
      end
    end
    if (buf_end && next_last && (next_total != 12'(next_pkt_len)))
      err_set = 1'b1;
    // a new error wins over a clear in the same cycle
    next_err = err_set || (TRANSMIT_ERROR_FLAG && !ERROR_CLEAR);
    next_loaded = buf_end && next_done_req;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      st <= ST_CMDA;
      cnt <= 11'h000;
      total <= 12'h000;
      pkt_len <= 11'h000;
      skip <= 3'h0;
      pad <= 3'h0;
      off_byte <= 2'h0;
      idx <= 2'h0;
      hold <= 32'h0000_0000;
      first <= 1'b0;
      last <= 1'b0;
      done_req <= 1'b0;
      first_word <= 1'b0;
      FRAME_TAG <= `TXBCP_RST_TAG;
      CHECKSUM_REQUEST <= 1'b0;
      CRC_APPEND <= 1'b1;
      PAD_ENABLE <= 1'b1;
      TRANSMIT_ERROR_FLAG <= 1'b0;
      BUFFER_LOADED_FLAG <= 1'b0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      total <= next_total;
      pkt_len <= next_pkt_len;
      skip <= next_skip;
      pad <= next_pad;
      off_byte <= next_off_byte;
      idx <= next_idx;
      hold <= next_hold;
      first <= next_first;
      last <= next_last;
      done_req <= next_done_req;
      first_word <= next_first_word;
      FRAME_TAG <= next_tag;
      CHECKSUM_REQUEST <= next_ck;
      CRC_APPEND <= next_crc;
      PAD_ENABLE <= next_padq;
      TRANSMIT_ERROR_FLAG <= next_err;
      BUFFER_LOADED_FLAG <= next_loaded;
    end
  end

  // the fifo decouples the parser from a stalling mac side
  txbcp_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_data   ({last && (cnt == 11'h1), pick_byte(hold, idx)}),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (fifo_out),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY)
  );
  assign OUT_DATA = fifo_out[7:0];
  assign OUT_LAST = fifo_out[8];
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_first_takes_b:
    assert property (st == ST_CMDA && IN_VALID && IN_DATA[13] |=> st == ST_CMDB)
      else $error("first buffer did not expect command B");
  a_size_latched:
    assert property (st == ST_CMDA && IN_VALID |=> cnt == $past(IN_DATA[10:0]))
      else $error("buffer size not taken from command A");
  a_total_restart:
    assert property (st == ST_CMDA && IN_VALID && IN_DATA[13] |=> total == {1'b0, $past(IN_DATA[10:0])})
      else $error("packet total not restarted");
  a_len_mismatch:
    assert property (buf_end && next_last && next_total != {1'b0, next_pkt_len} |=> TRANSMIT_ERROR_FLAG)
      else $error("length mismatch not flagged");
  a_tag_copy:
    assert property (st == ST_CMDB && IN_VALID |=> FRAME_TAG == $past(IN_DATA[31:16]))
      else $error("tag not copied");
  a_cksum_gate:
    assert property (st == ST_CMDB && IN_VALID |=>
                     CHECKSUM_REQUEST == $past(IN_DATA[14] && first && CHECKSUM_ENGINE_ENABLE))
      else $error("checksum request wrongly gated");
  a_crc_pad:
    assert property (!CRC_APPEND |-> PAD_ENABLE)
      else $error("crc dropped while padding disabled");
  a_lane_pick:
    assert property (st == ST_DATA && IN_VALID && first_word |=> st == ST_BYTES && idx == $past(off_byte))
      else $error("wrong first byte lane");
  a_skip_count:
    assert property (st == ST_SKIP && IN_VALID && skip > 3'h1 |=> st == ST_SKIP && skip == $past(skip) - 3'h1)
      else $error("offset dwords not skipped");
  a_filler_drop:
    assert property (st == ST_PAD |=> $stable(u_fifo.wr_ptr))
      else $error("filler forwarded");
  a_loaded_pulse:
    assert property (BUFFER_LOADED_FLAG |-> st == ST_CMDA)
      else $error("loaded flag raised before buffer end");
  a_stall_hold:
    assert property (st == ST_BYTES && !fifo_ready |=> st == ST_BYTES && $stable(cnt))
      else $error("byte lost under back-pressure");

  c_error: cover property (!TRANSMIT_ERROR_FLAG ##1 TRANSMIT_ERROR_FLAG);
  c_loaded: cover property (BUFFER_LOADED_FLAG);
  c_filler: cover property (st == ST_PAD ##1 st == ST_CMDA);
  c_skip: cover property (st == ST_SKIP ##1 st == ST_DATA);
endmodule

// *** rtl/txbcp_map.svh ***
// field positions, codes and reset values of the transmit buffer command parser
`ifndef TXBCP_MAP_SVH
`define TXBCP_MAP_SVH
`define TXBCP_A_DONE_BIT   31
`define TXBCP_A_ALIGN_LO   24
`define TXBCP_A_OFF_LO     16
`define TXBCP_A_FIRST_BIT  13
`define TXBCP_A_LAST_BIT   12
`define TXBCP_SIZE_HI      10
`define TXBCP_B_TAG_LO     16
`define TXBCP_B_CK_BIT     14
`define TXBCP_B_NOCRC_BIT  13
`define TXBCP_B_NOPAD_BIT  12
`define TXBCP_ALIGN_4      2'h0
`define TXBCP_ALIGN_16     2'h1
`define TXBCP_ALIGN_32     2'h2
`define TXBCP_ALIGN_RSVD   2'h3
`define TXBCP_MASK_16      3'h3
`define TXBCP_MASK_32      3'h7
`define TXBCP_FIFO_DEPTH   32
`define TXBCP_RST_TAG      16'h0000
`endif

// *** rtl/txbcp_pkg.sv ***
// types shared by the transmit buffer command parser
package txbcp_pkg;
  typedef enum logic [2:0] {
    ST_CMDA  = 3'b000,
    ST_CMDB  = 3'b001,
    ST_SKIP  = 3'b010,
    ST_DATA  = 3'b011,
    ST_BYTES = 3'b100,
    ST_PAD   = 3'b101
  } txbcp_state_type;
endpackage

// *** rtl/txbcp_fifo.sv ***
// synchronous fifo with valid/ready on both sides
module txbcp_fifo
  import txbcp_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             wr;
  logic             rd;

  assign in_ready  = (count != AW'(0) + (AW+1)'(DEPTH)) ;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb
  begin
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    next_wr_ptr = wr ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = rd ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
    if (wr)
      mem[wr_ptr] <= in_data;
  end
endmodule

// *** tb/txbcp_host_model.sv ***
// host model writing transmit buffers into the parser as a dword stream
module txbcp_host_model
(
  // clock
  input  wire logic        clk,
  // dword stream
  input  wire logic        in_ready,
  output logic      [31:0] in_data,
  output logic             in_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h47ff66d1;
  bit slow = 1'b1;

  initial
  begin
    in_valid = 1'b0;
    in_data  = 32'h0;
  end

  // idle data flips each cycle so a stale word never passes for a fresh one
  task automatic idle();
    @(negedge clk);
    in_valid = 1'b0;
    in_data  = ~in_data;
  endtask

  // word and valid held until the edge that sees ready high
  task automatic send(input logic [31:0] w);
    int gap;
    gap = slow ? {$random(seed)} % 3 : 0;
    repeat (gap) idle();
    @(negedge clk);
    in_valid = 1'b1;
    in_data  = w;
    while (!in_ready)
      @(negedge clk);
    @(posedge clk);
  endtask

  task automatic write_buffer(input logic [31:0] cmd_a, input logic [31:0] cmd_b, input logic [7:0] pay[$]);
    logic [31:0] w;
    int          n, body, al, k, lane;
    lane = cmd_a[17:16];
    send(cmd_a);
    if (cmd_a[13])
      send(cmd_b);
    repeat (cmd_a[20:18]) send($random(seed));
    n = pay.size() == 0 ? 0 : (lane + pay.size() + 3) / 4;
    for (int i = 0; i < n; i++)
    begin
      w = $random(seed);
      for (int j = 0; j < 4; j++)
      begin
        k = i * 4 + j - lane;
        if (k >= 0 && k < pay.size())
          w[8 * j +: 8] = pay[k];
      end
      send(w);
    end
    body = cmd_a[20:18] + n;
    al   = cmd_a[25:24] == 2'h1 ? 4 : (cmd_a[25:24] == 2'h2 ? 8 : 1);
    repeat ((al - body % al) % al) send($random(seed));
  endtask
endmodule

// *** tb/txbcp_parser_test.sv ***
// self-checking bench of the transmit buffer command parser
module txbcp_parser_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  logic        CLK_SYS = 1'b0;
  logic        RST = 1'b1;
  logic [31:0] IN_DATA;
  logic        IN_VALID;
  logic        IN_READY;
  logic [7:0]  OUT_DATA;
  logic        OUT_LAST;
  logic        OUT_VALID;
  logic        OUT_READY = 1'b0;
  logic [15:0] FRAME_TAG;
  logic        CHECKSUM_REQUEST;
  logic        CRC_APPEND;
  logic        PAD_ENABLE;
  logic        CHECKSUM_ENGINE_ENABLE = 1'b0;
  logic        ERROR_CLEAR = 1'b0;
  logic        TRANSMIT_ERROR_FLAG;
  logic        BUFFER_LOADED_FLAG;
  int          seed = 32'h47ff66d1;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          loaded_cnt = 0;
  int          exp_loaded = 0;
  bit          stall = 1'b0;
  logic [8:0]  got[$];
  logic [8:0]  want[$];

  always #10 CLK_SYS = ~CLK_SYS;

  txbcp_parser #(.FIFO_DEPTH(DEPTH)) dut
  (
    .CLK_SYS(CLK_SYS), .RST(RST), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
    .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .FRAME_TAG(FRAME_TAG), .CHECKSUM_REQUEST(CHECKSUM_REQUEST), .CRC_APPEND(CRC_APPEND),
    .PAD_ENABLE(PAD_ENABLE), .CHECKSUM_ENGINE_ENABLE(CHECKSUM_ENGINE_ENABLE), .ERROR_CLEAR(ERROR_CLEAR),
    .TRANSMIT_ERROR_FLAG(TRANSMIT_ERROR_FLAG), .BUFFER_LOADED_FLAG(BUFFER_LOADED_FLAG)
  );

  txbcp_host_model host
  (
    .clk(CLK_SYS), .in_ready(IN_READY), .in_data(IN_DATA), .in_valid(IN_VALID)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
    n_checks++;
    if (seen !== exp_v)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp_v);
    end
  endtask

  // consumer stalls at random so the fifo backs up now and then
  always @(negedge CLK_SYS)
  begin
    OUT_READY <= !stall && ({$random(seed)} % 4 != 0);
  end

  always @(posedge CLK_SYS)
  begin
    if (!RST && OUT_VALID && OUT_READY)
      got.push_back({OUT_LAST, OUT_DATA});
    if (!RST && BUFFER_LOADED_FLAG)
      loaded_cnt++;
    cycles++;
    if (cycles == 50000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic packet(input int nb, input bit bad, input int alsel, input bit big);
    logic [7:0]  pay[$];
    logic [10:0] sz[$];
    logic [10:0] total;
    logic [15:0] tag;
    logic [1:0]  al;
    logic [31:0] b;
    logic        ck, nocrc, nopad, ena, err, fst, lst, done;
    int          tmo;
    total = 11'h0;
    err   = bad;
    for (int i = 0; i < nb; i++)
    begin
      sz.push_back(big ? 11'h3c : 11'({$random(seed)} % 40));
      if (i > 0 && i < nb - 1 && sz[i] < 4)
        sz[i] = 11'h4;
      total += sz[i];
    end
    tag = 16'($random(seed));
    {ck, nocrc, nopad, ena} = 4'($random(seed));
    @(negedge CLK_SYS);
    CHECKSUM_ENGINE_ENABLE = ena;
    b = {tag, 1'b0, ck, nocrc, nopad, 1'b0, total + 11'(bad)};
    for (int i = 0; i < nb; i++)
    begin
      fst = (i == 0);
      lst = (i == nb - 1);
      al  = alsel < 0 ? 2'({$random(seed)} % 3) : 2'(alsel);
      err |= (al == 2'h3);
      done = 1'($random(seed));
      exp_loaded += done;
      pay.delete();
      for (int j = 0; j < sz[i]; j++)
      begin
        pay.push_back(8'($random(seed)));
        want.push_back({lst && j == sz[i] - 1, pay[j]});
      end
      host.write_buffer({done, 5'h0, al, 3'h0, 3'($random(seed)), 2'($random(seed)), 2'h0, fst, lst, 1'b0, sz[i]},
                        b, pay);
    end
    host.idle();
    tmo = 0;
    while (got.size() < want.size() && tmo < 3000)
    begin
      @(negedge CLK_SYS);
      tmo++;
    end
    repeat (8) @(negedge CLK_SYS);
    check(got.size(), want.size());
    while (got.size() > 0 && want.size() > 0)
      check(got.pop_front(), want.pop_front());
    got.delete();
    want.delete();
    check(TRANSMIT_ERROR_FLAG, err);
    check(FRAME_TAG, tag);
    check(CHECKSUM_REQUEST, ck & ena);
    check(CRC_APPEND, !nocrc | nopad);
    check(PAD_ENABLE, !nopad);
    check(loaded_cnt, exp_loaded);
    ERROR_CLEAR = 1'b1;
    @(negedge CLK_SYS);
    ERROR_CLEAR = 1'b0;
    @(negedge CLK_SYS);
    check(TRANSMIT_ERROR_FLAG, 1'b0);
  endtask

  initial
  begin
    repeat (2) @(negedge CLK_SYS);
    RST = 1'b0;
    check(IN_READY, 1'b1);
    check(OUT_VALID, 1'b0);
    check({FRAME_TAG, CHECKSUM_REQUEST, CRC_APPEND, PAD_ENABLE}, 19'h3);
    check({TRANSMIT_ERROR_FLAG, BUFFER_LOADED_FLAG}, 2'h0);
    for (int c = 0; c < 3; c++)
      packet(1, 1'b0, c, 1'b0);
    packet(3, 1'b1, -1, 1'b0);
    packet(2, 1'b0, 3, 1'b0);
    // fifo filled until the parser refuses, then drained
    host.slow = 1'b0;
    stall = 1'b1;
    fork
      packet(1, 1'b0, 0, 1'b1);
      begin
        repeat (40) @(negedge CLK_SYS);
        check(IN_READY, 1'b0);
        check(OUT_VALID, 1'b1);
        stall = 1'b0;
      end
    join
    host.slow = 1'b1;
    repeat (25) packet(1 + {$random(seed)} % 3, {$random(seed)} % 4 == 0, -1, 1'b0);
    end_of_test();
  end
endmodule
